// >>> design/ap_err_top.sv
/*
 * Debug memory access port error handling: register decode on Avalon-MM,
 * per-port sticky errors, stop-on-error, access grants and abort handling.
 * Assumes synchronous grant and abort inputs and one APB memory slave.
 */
// Summary of operation
// (R1) config field reports error handling version one
// (R2) logged memory errors set sticky error flag
// (R3) sticky flag clears only by writing one
// (R4) access without port grant is logged error
// (R5) secure access without secure grant errors
// (R6) master side error response logged as failure
// (R7) abort logged, always answered with error
// (R8) access during post-abort transfer: busy error
// (R9) register errors never logged, always returned
// (R10) register write during post-abort transfer errors
// (R11) no-pass bit turns maskable errors into okay
// (R12) read data undefined on error answers
// (R13) clear sticky flag never blocks accesses
// (R14) sticky set, stop clear: accesses continue
// (R15) sticky and stop: block, log, maybe answer
// (R16) any non-maskable source forces error answer
// (R17) each logical port keeps own error state
// (R18) grant changes apply from next transfer
// (R19) after stop, grants sampled first run cycle
// (R20) abort answers now, master transfer continues
// (R21) in-progress flag spans master transfer end
`timescale 1ns/100ps
`default_nettype none
module ap_err_top
    import ap_err_pkg::*;
(
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic [ap_err_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [ap_err_pkg::DATA_W-1:0] AVS_WRITEDATA_IN,
    output logic [ap_err_pkg::DATA_W-1:0] AVS_READDATA_OUT,
    output logic [1:0] AVS_RESPONSE_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire logic ABORT_IN,
    input wire logic PORT_GRANT_IN,
    input wire logic SECURE_GRANT_IN,
    input wire logic QREQ_N_IN,
    output logic QACCEPT_N_OUT,
    output logic QDENY_OUT,
    output logic QACTIVE_OUT,
    output logic PSEL_OUT,
    output logic PENABLE_OUT,
    output logic PWRITE_OUT,
    output logic [ap_err_pkg::DATA_W-1:0] PADDR_OUT,
    output logic [ap_err_pkg::DATA_W-1:0] PWDATA_OUT,
    output logic [2:0] PPROT_OUT,
    input wire logic [ap_err_pkg::DATA_W-1:0] PRDATA_IN,
    input wire logic PREADY_IN,
    input wire logic PSLVERR_IN
);
    import ap_err_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    mem_req_if mem ();

    acc_state_t st_r;
    q_state_t q_r;
    logic run_ok_r;
    logic grant_r;
    logic sec_grant_r;
    logic owner_r;
    logic start_r;
    logic wr_r;
    logic sec_r;
    logic [DATA_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;

    logic [CTRL_W-1:0] ctrl [NUM_AP];
    logic [DATA_W-1:0] tar [NUM_AP];
    logic sticky [NUM_AP];
    logic tip [NUM_AP];
    logic err_set [NUM_AP];

    logic req;
    logic sel;
    logic [OFF_W-1:0] off;
    logic take;
    logic other_busy;
    logic dec_start;
    logic dec_log;
    logic dec_csw_we;
    logic dec_tar_we;
    logic dec_w1c;
    logic [1:0] dec_resp;
    logic [DATA_W-1:0] dec_data;
    logic auth_fail;
    logic stop_fail;
    logic mem_log;
    logic idle;

    ////////////////////////////////////////////////////////////////////////
    // per logical port state

    genvar gi;
    generate
        for (gi = 0; gi < NUM_AP; gi++) begin : g_ap
            localparam logic IDX = 1'(gi);
            assign tip[gi] = mem.busy && (owner_r == IDX); // R21
            // errors of one port never touch the other
            assign err_set[gi] = (take && dec_log && sel == IDX) // R17
                || (mem_log && owner_r == IDX);
            ap_ctx u_ctx (
                .clk_in(CORE_CLK_IN),
                .rst_in(RST_IN),
                .csw_we_in(take && dec_csw_we && sel == IDX),
                .tar_we_in(take && dec_tar_we && sel == IDX),
                .w1c_in(take && dec_w1c && sel == IDX),
                .err_set_in(err_set[gi]),
                .wdata_in(AVS_WRITEDATA_IN),
                .ctrl_out(ctrl[gi]),
                .tar_out(tar[gi]),
                .sticky_out(sticky[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // request decode

    assign req = AVS_READ_IN || AVS_WRITE_IN;
    assign sel = AVS_ADDRESS_IN[AP_SEL_BIT];
    assign off = AVS_ADDRESS_IN[OFF_W-1:0];
    // a memory access on one port waits while the other port's transfer runs
    assign other_busy = (off == OFF_DRW) && mem.busy && !tip[sel];
    assign take = req && AVS_WAITREQUEST_OUT && st_r == S_IDLE
        && q_r == Q_RUN && run_ok_r && !other_busy; // R19
    assign auth_fail = !grant_r || (ctrl[sel][CSW_SEC] && !sec_grant_r); // R4 R5
    assign stop_fail = sticky[sel] && ctrl[sel][CSW_STOP]; // R13 R14 R15
    assign mem_log = st_r == S_MEM && (ABORT_IN || (mem.done && mem.err)); // R6 R7
    assign idle = st_r == S_IDLE && !mem.busy && !req && !start_r;

    always_comb begin
        dec_start = 1'b0;
        dec_log = 1'b0;
        dec_csw_we = 1'b0;
        dec_tar_we = 1'b0;
        dec_w1c = 1'b0;
        dec_resp = RESP_OK;
        dec_data = ZERO_W;
        unique case (off)
            OFF_CSW: begin
                dec_data[CTRL_W-1:0] = ctrl[sel];
                dec_data[CSW_TIP] = tip[sel];
                if (AVS_WRITE_IN && tip[sel]) dec_resp = RESP_SLVERR; // R10
                else dec_csw_we = AVS_WRITE_IN;
            end
            OFF_TAR: begin
                dec_data = tar[sel];
                if (AVS_WRITE_IN && tip[sel]) dec_resp = RESP_SLVERR; // R10
                else dec_tar_we = AVS_WRITE_IN;
            end
            OFF_TRR: begin
                dec_data[TRANSFER_ERROR_STICKY] = sticky[sel];
                if (AVS_WRITE_IN && tip[sel]) dec_resp = RESP_SLVERR; // R10
                else dec_w1c = AVS_WRITE_IN && AVS_WRITEDATA_IN[TRANSFER_ERROR_STICKY]; // R3
            end
            OFF_CFG: begin
                dec_data[CFG_ERR_LSB +: 4] = ERR_VERSION; // R1
                if (AVS_WRITE_IN) dec_resp = RESP_SLVERR; // R9
            end
            OFF_DRW: begin
                if (tip[sel]) begin
                    // master busy after an abort cannot be masked
                    dec_log = 1'b1; // R8
                    dec_resp = RESP_SLVERR; // R8 R16
                end else if (auth_fail || stop_fail) begin
                    dec_log = 1'b1; // R4 R5 R15
                    dec_resp = ctrl[sel][CSW_ENP] ? RESP_OK : RESP_SLVERR; // R11 R16
                end else begin
                    dec_start = 1'b1; // R13 R14
                end
            end
            default: dec_resp = RESP_DECERR; // R9
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencing and answers

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_r <= S_IDLE;
            AVS_WAITREQUEST_OUT <= 1'b1;
            AVS_RESPONSE_OUT <= RESP_OK;
            AVS_READDATA_OUT <= ZERO_W;
        end else begin
            AVS_WAITREQUEST_OUT <= 1'b1;
            unique case (st_r)
                S_IDLE: begin
                    if (take && dec_start) begin
                        st_r <= S_MEM;
                    end else if (take) begin
                        AVS_WAITREQUEST_OUT <= 1'b0;
                        AVS_RESPONSE_OUT <= dec_resp;
                        AVS_READDATA_OUT <= dec_data; // R12
                    end
                end
                S_MEM: begin
                    if (ABORT_IN) begin
                        // answer now; the master transfer keeps running
                        st_r <= S_IDLE; // R20
                        AVS_WAITREQUEST_OUT <= 1'b0;
                        AVS_RESPONSE_OUT <= RESP_SLVERR; // R7
                    end else if (mem.done) begin
                        st_r <= S_IDLE;
                        AVS_WAITREQUEST_OUT <= 1'b0;
                        AVS_READDATA_OUT <= mem.rdata; // R12
                        AVS_RESPONSE_OUT <= (mem.err && !ctrl[owner_r][CSW_ENP])
                            ? RESP_SLVERR : RESP_OK; // R6 R11
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            start_r <= 1'b0;
            owner_r <= 1'b0;
            wr_r <= 1'b0;
            sec_r <= 1'b0;
            addr_r <= ZERO_W;
            wdata_r <= ZERO_W;
        end else begin
            start_r <= take && dec_start;
            if (take && dec_start) begin
                owner_r <= sel;
                wr_r <= AVS_WRITE_IN;
                sec_r <= ctrl[sel][CSW_SEC];
                addr_r <= tar[sel];
                wdata_r <= AVS_WRITEDATA_IN;
            end
        end
    end

    assign mem.start = start_r;
    assign mem.write = wr_r;
    assign mem.secure = sec_r;
    assign mem.addr = addr_r;
    assign mem.wdata = wdata_r;

    apb_mem_master u_mst (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .mem(mem.mst),
        .psel_out(PSEL_OUT),
        .penable_out(PENABLE_OUT),
        .pwrite_out(PWRITE_OUT),
        .paddr_out(PADDR_OUT),
        .pwdata_out(PWDATA_OUT),
        .pprot_out(PPROT_OUT),
        .prdata_in(PRDATA_IN),
        .pready_in(PREADY_IN),
        .pslverr_in(PSLVERR_IN)
    );

    ////////////////////////////////////////////////////////////////////////
    // low-power channel and grant sampling

    // grants are only looked at when a transfer is decided, so a change
    // in the middle of a running transfer has no effect on it
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            grant_r <= 1'b0;
            sec_grant_r <= 1'b0;
            run_ok_r <= 1'b0;
        end else begin
            run_ok_r <= q_r == Q_RUN && QREQ_N_IN; // R19
            if (q_r == Q_RUN) begin
                grant_r <= PORT_GRANT_IN; // R18
                sec_grant_r <= SECURE_GRANT_IN; // R18
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            q_r <= Q_RUN;
            QACCEPT_N_OUT <= 1'b1;
            QDENY_OUT <= 1'b0;
            QACTIVE_OUT <= 1'b0;
        end else begin
            QACTIVE_OUT <= req || mem.busy || st_r != S_IDLE;
            unique case (q_r)
                Q_RUN: begin
                    if (!QREQ_N_IN && idle) begin
                        q_r <= Q_STOPPED;
                        QACCEPT_N_OUT <= 1'b0;
                    end else if (!QREQ_N_IN) begin
                        q_r <= Q_DENIED;
                        QDENY_OUT <= 1'b1;
                    end
                end
                Q_STOPPED: begin
                    if (QREQ_N_IN) begin
                        q_r <= Q_RUN;
                        QACCEPT_N_OUT <= 1'b1;
                    end
                end
                Q_DENIED: begin
                    if (QREQ_N_IN) begin
                        q_r <= Q_RUN;
                        QDENY_OUT <= 1'b0;
                    end
                end
                default: q_r <= Q_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_cfg_version: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R1
        take && AVS_READ_IN && off == OFF_CFG
        |=> AVS_READDATA_OUT[CFG_ERR_LSB +: 4] == ERR_VERSION)
        else $error("config read did not report version one");
    a_abort_error: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R7
        st_r == S_MEM && ABORT_IN
        |=> !AVS_WAITREQUEST_OUT && AVS_RESPONSE_OUT == RESP_SLVERR)
        else $error("abort not answered with an error");
    a_busy_error: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R8
        take && off == OFF_DRW && tip[sel]
        |=> AVS_RESPONSE_OUT == RESP_SLVERR && !start_r)
        else $error("master busy access not refused");
    a_stop_blocks: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R15
        start_r |-> $past(!stop_fail && grant_r))
        else $error("transfer started while blocked");
    a_nopass_ok: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R11
        st_r == S_MEM && !ABORT_IN && mem.done && ctrl[owner_r][CSW_ENP]
        |=> AVS_RESPONSE_OUT == RESP_OK)
        else $error("masked memory error still returned");
    a_reg_nolog: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R9
        take && off != OFF_DRW |-> !err_set[sel])
        else $error("register access logged an error");
    a_sample_run: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R19
        $rose(q_r == Q_RUN) |-> !take ##1 (grant_r == $past(PORT_GRANT_IN)))
        else $error("request decided before grants were resampled");
    a_tip_abort: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN) // R21
        st_r == S_MEM && ABORT_IN && mem.busy |=> tip[owner_r])
        else $error("in-progress flag lost on abort");
endmodule
`default_nettype wire

// >>> include/ap_err_pkg.sv
/*
 * Shared constants and types for the access port error handling block.
 * Assumes a 32-bit Avalon-MM register bus and a 32-bit APB memory side.
 */
package ap_err_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 9;
    localparam int NUM_AP = 2;
    localparam int AP_SEL_BIT = 8;
    localparam int OFF_W = 8;
    // byte offsets inside one logical port
    localparam logic [7:0] OFF_CSW = 8'h00;
    localparam logic [7:0] OFF_TAR = 8'h04;
    localparam logic [7:0] OFF_DRW = 8'h0c;
    localparam logic [7:0] OFF_TRR = 8'h10;
    localparam logic [7:0] OFF_CFG = 8'h14;
    // control/status field layout
    localparam int CTRL_W = 3;
    localparam int CSW_ENP = 0;
    localparam int CSW_STOP = 1;
    localparam int CSW_SEC = 2;
    localparam int CSW_TIP = 7;
    localparam int TRANSFER_ERROR_STICKY = 0;
    localparam int CFG_ERR_LSB = 8;
    localparam logic [3:0] ERR_VERSION = 4'h1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [31:0] TAR_RST = 32'h0;
    localparam logic [31:0] ZERO_W = 32'h0;
    // avalon response codes
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [2:0] PROT_SEC = 3'h0;
    localparam logic [2:0] PROT_NS = 3'h2;
    typedef enum logic [0:0] {S_IDLE, S_MEM} acc_state_t;
    typedef enum logic [1:0] {Q_RUN, Q_STOPPED, Q_DENIED} q_state_t;
endpackage

// >>> include/mem_req_if.sv
/*
 * Request and answer bundle between the port logic and its memory master.
 * Assumes one outstanding transfer; start is a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
interface mem_req_if;
    import ap_err_pkg::*;
    logic start;
    logic write;
    logic secure;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic err;
    logic busy;
    modport host (output start, write, secure, addr, wdata, input rdata, done, err, busy);
    modport mst (input start, write, secure, addr, wdata, output rdata, done, err, busy);
endinterface
`default_nettype wire

// >>> design/ap_ctx.sv
/*
 * Per logical port context: control bits, transfer address and sticky error.
 * Assumes strobes come from the register decoder, one cycle each.
 */
`timescale 1ns/100ps
`default_nettype none
module ap_ctx
    import ap_err_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic csw_we_in,
    input wire logic tar_we_in,
    input wire logic w1c_in,
    input wire logic err_set_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic [CTRL_W-1:0] ctrl_out,
    output logic [DATA_W-1:0] tar_out,
    output logic sticky_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_out <= CTRL_RST;
            tar_out <= TAR_RST;
        end else begin
            if (csw_we_in) ctrl_out <= wdata_in[CTRL_W-1:0];
            if (tar_we_in) tar_out <= wdata_in;
        end
    end

    // a new error wins over a clear in the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) sticky_out <= 1'b0;
        else if (err_set_in) sticky_out <= 1'b1; // R2
        else if (w1c_in) sticky_out <= 1'b0; // R3
    end

    a_sticky_set: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        err_set_in |=> sticky_out) else $error("error event did not set sticky flag");
    a_sticky_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        w1c_in && !err_set_in |=> !sticky_out) else $error("write one did not clear");
    a_sticky_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        sticky_out && !w1c_in |=> sticky_out) else $error("sticky flag dropped alone");
endmodule
`default_nettype wire

// >>> design/apb_mem_master.sv
/*
 * APB master for the memory side: one transfer per start pulse.
 * Assumes the slave eventually raises pready; no timeout here.
 */
`timescale 1ns/100ps
`default_nettype none
module apb_mem_master
    import ap_err_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    mem_req_if.mst mem,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [DATA_W-1:0] paddr_out,
    output logic [DATA_W-1:0] pwdata_out,
    output logic [2:0] pprot_out,
    input wire logic [DATA_W-1:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    // an abort never cuts a transfer short: it runs to pready
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            psel_out <= 1'b0;
            penable_out <= 1'b0;
            pwrite_out <= 1'b0;
            paddr_out <= ZERO_W;
            pwdata_out <= ZERO_W;
            pprot_out <= PROT_SEC;
            mem.busy <= 1'b0;
            mem.done <= 1'b0;
            mem.err <= 1'b0;
            mem.rdata <= ZERO_W;
        end else begin
            mem.done <= 1'b0;
            if (mem.start && !mem.busy) begin
                psel_out <= 1'b1;
                pwrite_out <= mem.write;
                paddr_out <= mem.addr;
                pwdata_out <= mem.wdata;
                pprot_out <= mem.secure ? PROT_SEC : PROT_NS;
                mem.busy <= 1'b1; // R21
            end else if (psel_out && !penable_out) begin
                penable_out <= 1'b1;
            end else if (psel_out && pready_in) begin // R20
                psel_out <= 1'b0;
                penable_out <= 1'b0;
                mem.busy <= 1'b0; // R21
                mem.done <= 1'b1;
                mem.err <= pslverr_in;
                mem.rdata <= prdata_in;
            end
        end
    end

    sequence s_setup;
        psel_out && !penable_out;
    endsequence
    sequence s_access;
        psel_out && penable_out;
    endsequence
    a_apb_phases: assert property (@(posedge clk_in) disable iff (rst_in) // R21
        mem.start && !mem.busy |=> s_setup ##1 s_access)
        else $error("apb setup and access phases out of order");
    a_busy_done: assert property (@(posedge clk_in) disable iff (rst_in) // R21
        $fell(mem.busy) |-> mem.done && !psel_out)
        else $error("busy fell without a completed transfer");
endmodule
`default_nettype wire

// >>> tb/apb_mem_model.sv
/* APB memory slave at the far side of the port.
   Assumes the bench sets err_in between transfers; stall_in may also drop while a transfer waits. */
`timescale 1ns/100ps
`default_nettype none
module apb_mem_model (
    input wire logic clk_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [31:0] paddr_in,
    input wire logic err_in,
    input wire logic stall_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);
    logic [1:0] wait_r = 2'h0;
    logic tog_r = 1'b0;
    always @(posedge clk_in) begin
        tog_r <= ~tog_r;
        if (psel_in && !penable_in)
            wait_r <= 2'($urandom_range(0, 2));
        else if (penable_in && wait_r != 2'h0)
            wait_r <= wait_r - 2'h1;
    end
    assign pready_out = psel_in && penable_in && wait_r == 2'h0 && !stall_in;
    // no stale data outside the answer cycle
    assign prdata_out = pready_out ? ~paddr_in : {32{tog_r}} ^ paddr_in;
    assign pslverr_out = pready_out && err_in;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/* Self-checking bench for ap_err_top with a queue-free reference model.
   Assumes the APB slave model above and the register map of the package. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ap_err_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd, wr, abort, pgr, sgr, serr, stall;
    logic wreq, psel, pen, pready, pslverr, qn, qacc;
    logic [8:0] adr;
    logic [31:0] wd, rdat, paddr, prdata;
    logic [1:0] resp;
    logic [31:0] tar[2];
    int miscompares = 0;
    int checked = 0;
    int starts = 0;
    int sticky[2], nopass[2], stop[2], sec[2];
    always #12.5 clk = ~clk;
    always @(posedge clk) if (psel && !pen) starts <= starts + 1;
    ap_err_top i_ap_err_top (.CORE_CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
        .AVS_RESPONSE_OUT(resp), .AVS_WAITREQUEST_OUT(wreq), .ABORT_IN(abort),
        .PORT_GRANT_IN(pgr), .SECURE_GRANT_IN(sgr), .QREQ_N_IN(qn), .QACCEPT_N_OUT(qacc),
        .QDENY_OUT(), .QACTIVE_OUT(), .PSEL_OUT(psel), .PENABLE_OUT(pen), .PWRITE_OUT(),
        .PADDR_OUT(paddr), .PWDATA_OUT(), .PPROT_OUT(), .PRDATA_IN(prdata),
        .PREADY_IN(pready), .PSLVERR_IN(pslverr));
    apb_mem_model i_apb_mem_model (.clk_in(clk), .psel_in(psel), .penable_in(pen),
        .paddr_in(paddr), .err_in(serr), .stall_in(stall), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr));
    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request, held until waitrequest is sampled low
    task automatic av(bit w, logic [8:0] a, logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] r);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        // only the watchdog ends a wait that never gets an answer
        do @(posedge clk);
        while (wreq !== 1'b0);
        q = rdat;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rg(bit w, int p, logic [7:0] o, logic [31:0] d, logic [1:0] er,
                      output logic [31:0] q);
        logic [1:0] r;
        av(w, {p[0], o}, d, q, r);
        chk("reg resp", er, r);
    endtask
    task automatic setc(int p, bit np, bit st, bit sc);
        logic [31:0] q;
        rg(1, p, OFF_CSW, {29'h0, sc, st, np}, RESP_OK, q);
        nopass[p] = np;
        stop[p] = st;
        sec[p] = sc;
    endtask
    task automatic settar(int p);
        logic [31:0] q;
        tar[p] = $urandom;
        rg(1, p, OFF_TAR, tar[p], RESP_OK, q);
    endtask
    task automatic drw(int p, bit e);
        logic [31:0] q;
        logic [1:0] r;
        int s0;
        bit blk;
        bit fail;
        serr <= e;
        s0 = starts;
        av(0, {p[0], OFF_DRW}, 32'h0, q, r);
        blk = !pgr || (sec[p] && !sgr) || (sticky[p] && stop[p]);
        fail = blk || e;
        chk("started", blk ? 0 : 1, starts - s0);
        chk("drw resp", (fail && !nopass[p]) ? RESP_SLVERR : RESP_OK, r);
        if (!fail) chk("drw data", ~tar[p], q);
        if (fail) sticky[p] = 1;
        rg(0, p, OFF_TRR, 0, RESP_OK, q);
        chk("sticky", sticky[p], q[TRANSFER_ERROR_STICKY]);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #500000;
        miscompares++;
        results();
    end
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        {rd, wr, abort, serr, stall, adr, wd} = '0;
        {pgr, sgr, qn} = 3'h7;
        sticky = '{0, 0};
        nopass = '{0, 0};
        stop = '{0, 0};
        sec = '{0, 0};
        void'($urandom(87908));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rg(0, 0, OFF_CFG, 0, RESP_OK, q);
        chk("cfg", 32'h1, {28'h0, q[11:8]});
        rg(1, 1, OFF_CFG, 0, RESP_SLVERR, q);
        rg(0, 0, 8'h08, 0, RESP_DECERR, q);
        settar(0);
        settar(1);
        drw(0, 0);
        drw(0, 1);
        drw(1, 0);
        setc(0, 0, 1, 0);
        drw(0, 0);
        setc(0, 1, 1, 0);
        drw(0, 0);
        setc(0, 1, 0, 0);
        drw(0, 0);
        rg(1, 0, OFF_TRR, 32'h1, RESP_OK, q);
        sticky[0] = 0;
        drw(0, 0);
        pgr <= 1'b0;
        drw(1, 0);
        pgr <= 1'b1;
        sgr <= 1'b0;
        setc(1, 1, 0, 1);
        drw(1, 0);
        sgr <= 1'b1;
        stall <= 1'b1;
        fork
            av(0, {1'b0, OFF_DRW}, 32'h0, q, r);
            begin
                repeat (4) @(posedge clk);
                abort <= 1'b1;
                @(posedge clk);
                abort <= 1'b0;
            end
        join
        chk("abort resp", RESP_SLVERR, r);
        sticky[0] = 1;
        rg(0, 0, OFF_CSW, 0, RESP_OK, q);
        chk("in progress", 1, q[CSW_TIP]);
        rg(1, 0, OFF_CSW, 0, RESP_SLVERR, q);
        av(0, {1'b0, OFF_DRW}, 32'h0, q, r);
        chk("busy resp", RESP_SLVERR, r);
        stall <= 1'b0;
        q[CSW_TIP] = 1'b1;
        for (int i = 0; i < 20 && q[CSW_TIP] !== 1'b0; i++)
            rg(0, 0, OFF_CSW, 0, RESP_OK, q);
        chk("in progress", 0, q[CSW_TIP]);
        drw(1, 0);
        for (int i = 0; i < 24; i++) begin
            pgr <= 1'($urandom);
            sgr <= 1'($urandom);
            setc(i % 2, 1'($urandom), 1'($urandom), 1'($urandom));
            settar(i % 2);
            drw(i % 2, 1'($urandom));
        end
        // grant drops while stopped: the first run cycle must see it
        qn <= 1'b0;
        repeat (3) @(posedge clk);
        chk("qaccept", 0, qacc);
        pgr <= 1'b0;
        qn <= 1'b1;
        drw(0, 0);
        results();
    end
endmodule
`default_nettype wire
